// ### pgpc_consts.vh
// Register offsets, field layouts, reset values and widths of the seventh I/O port.
`ifndef PGPC_CONSTS_VH
`define PGPC_CONSTS_VH

`define PGPC_ADDR_W 4
`define PGPC_DATA_W 8
`define PGPC_PINS 8
`define PGPC_ANA_PINS 5
`define PGPC_COM_PINS 4

`define PGPC_OFS_PINS 4'h0
`define PGPC_OFS_LATCH 4'h1
`define PGPC_OFS_DIR 4'h2
`define PGPC_OFS_ANSEL 4'h3
`define PGPC_OFS_ODSEL 4'h4
`define PGPC_OFS_LCDSEG 4'h5
`define PGPC_OFS_LCDCOM 4'h6
`define PGPC_OFS_STATUS 4'h7

`define PGPC_RST_LATCH 8'h00
`define PGPC_RST_DIR 8'hff
`define PGPC_RST_ANSEL 5'h1f
`define PGPC_RST_ODSEL 5'h00
`define PGPC_RST_LCDSEG 5'h00
`define PGPC_RST_LCDCOM 4'h0

`define PGPC_NARROW_MASK 8'h3f
`define PGPC_WIDE_MASK 8'hff

`define PGPC_CH_PIN0 5'h08
`define PGPC_CH_PIN1 5'h13
`define PGPC_CH_PIN2 5'h12
`define PGPC_CH_PIN3 5'h11
`define PGPC_CH_PIN4 5'h10

`define PGPC_STAT_WIDE 7
`define PGPC_STAT_ROUTE_LSB 0

`endif

// ### pgpc_pin_mux.v
// Per-pin function selection of the seventh I/O port.
`timescale 1ns/1ps

module pgpc_pin_mux (
    // Software configuration.
    input wire dirIn,
    input wire latchVal,
    input wire analogSel,
    input wire openDrain,
    input wire present,
    // LCD drive.
    input wire lcdEn,
    input wire lcdVal,
    // Peripheral overrides.
    input wire perOutEn,
    input wire perOut,
    input wire perInForce,
    // Pin level.
    input wire pinLevel,
    // Results.
    output reg drvVal,
    output reg drvEnN,
    output reg digIn
);

    always @* begin
        drvVal = 1'b0;
        drvEnN = 1'b1;
        digIn = 1'b0;
        if (!present) begin
            drvEnN = 1'b1;
        end else if (lcdEn) begin
            // LCD drive owns the pin outright, including its input path.
            drvVal = lcdVal;
            drvEnN = 1'b0;
        end else if (perOutEn) begin
            // Direction bit is ignored; open drain only ever pulls low.
            drvVal = perOut;
            drvEnN = openDrain ? perOut : 1'b0;
            digIn = analogSel ? 1'b0 : pinLevel;
        end else if (perInForce) begin
            drvEnN = 1'b1;
            digIn = analogSel ? 1'b0 : pinLevel;
        end else begin
            // Analog selection gates only the input path, never the driver.
            drvVal = latchVal;
            drvEnN = dirIn;
            digIn = analogSel ? 1'b0 : pinLevel;
        end
    end

endmodule // pgpc_pin_mux

// ### pgpc_port.v
// Seventh general-purpose I/O port: registers, pin muxing and analog routing.
// How it works
// - six pins, eight on the wide package.
// - direction 0 drives latch, 1 reads pin.
// - peripheral override never changes stored direction.
// - peripherals may force output or input.
// - analog select kills digital input, not output.
// - pins 0-4 reset to analog inputs.
// - pins 0-4 map to channels 8,19,18,17,16.
// - LCD segment disables all other pin functions (on pins 0-3 an enabled LCD common still drives the pin instead).
// - LCD common disables other drivers, ignoring direction.
// - open-drain mode for capture and serial outputs.
// - don't-care direction functions override the direction bit.
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "pgpc_consts.vh"

module pgpc_port (
    // Clock and reset.
    input wire clk,
    input wire rst,
    // Package strap, caught while reset is held.
    input wire widePackage,
    // Register port.
    input wire [`PGPC_ADDR_W-1:0] regAddr,
    input wire [`PGPC_DATA_W-1:0] regWrData,
    input wire regWrite,
    input wire regRead,
    output reg [`PGPC_DATA_W-1:0] regRdData_q,
    // LCD drive levels for pins 0 to 4.
    input wire [`PGPC_ANA_PINS-1:0] lcdSegLevel,
    input wire [`PGPC_COM_PINS-1:0] lcdComLevel,
    // Remapped peripheral outputs and forced inputs, pins 0 to 4.
    input wire [`PGPC_ANA_PINS-1:0] remapOutEn,
    input wire [`PGPC_ANA_PINS-1:0] remapOut,
    input wire [`PGPC_ANA_PINS-1:0] remapInForce,
    // Clock calendar output on pin 4.
    input wire clockCalendarOutEn,
    input wire clockCalendarOut,
    // Converter channel being sampled.
    input wire [4:0] adcChannel,
    // Pins.
    input wire [`PGPC_PINS-1:0] pinIn,
    output reg [`PGPC_PINS-1:0] pinOut_q,
    output reg [`PGPC_PINS-1:0] pinOeN_q,
    // Digital pin levels to peripherals and analog routing.
    output reg [`PGPC_PINS-1:0] periphIn_q,
    output reg [`PGPC_ANA_PINS-1:0] analogRoute_q
);

    // Converter channel wired to each analog-capable pin.
    function [4:0] chanOfPin;
        input integer idx;
        begin
            case (idx)
                0: chanOfPin = `PGPC_CH_PIN0;
                1: chanOfPin = `PGPC_CH_PIN1;
                2: chanOfPin = `PGPC_CH_PIN2;
                3: chanOfPin = `PGPC_CH_PIN3;
                4: chanOfPin = `PGPC_CH_PIN4;
                default: chanOfPin = 5'h1f;
            endcase
        end
    endfunction

    // Address decode used by the write path; the read mux decodes regAddr with its own case.
    function isReg;
        input [`PGPC_ADDR_W-1:0] addr;
        input [`PGPC_ADDR_W-1:0] ofs;
        begin
            isReg = (addr == ofs);
        end
    endfunction

    reg [`PGPC_PINS-1:0] latch_q;
    reg [`PGPC_PINS-1:0] dir_q;
    reg [`PGPC_ANA_PINS-1:0] anaSel_q;
    reg [`PGPC_ANA_PINS-1:0] odSel_q;
    reg [`PGPC_ANA_PINS-1:0] lcdSegEn_q;
    reg [`PGPC_COM_PINS-1:0] lcdComEn_q;
    reg widePkg_q;
    reg [`PGPC_PINS-1:0] pinLevel_q;
    reg [`PGPC_DATA_W-1:0] rdData_d;

    wire [`PGPC_PINS-1:0] presentMask;
    wire [`PGPC_PINS-1:0] muxVal;
    wire [`PGPC_PINS-1:0] muxEnN;
    wire [`PGPC_PINS-1:0] muxIn;
    wire [`PGPC_ANA_PINS-1:0] routeHit;
    wire [`PGPC_PINS-1:0] wrMask;

    // Pins 6 and 7 only exist on the wide package.
    assign presentMask = widePkg_q ? `PGPC_WIDE_MASK : `PGPC_NARROW_MASK;
    assign wrMask = presentMask;

    // Reset is synchronous, so the strap is sampled while it is held.
    always @(posedge clk) begin
        if (rst) begin
            widePkg_q <= widePackage;
        end
    end

    // Register writes.
    always @(posedge clk) begin
        if (rst) begin
            latch_q <= `PGPC_RST_LATCH;
            dir_q <= `PGPC_RST_DIR;
            anaSel_q <= `PGPC_RST_ANSEL;
            odSel_q <= `PGPC_RST_ODSEL;
            lcdSegEn_q <= `PGPC_RST_LCDSEG;
            lcdComEn_q <= `PGPC_RST_LCDCOM;
        end else if (regWrite) begin
            // Writing the pin register lands in the latch, like the latch itself.
            if (isReg(regAddr, `PGPC_OFS_PINS) || isReg(regAddr, `PGPC_OFS_LATCH)) begin
                latch_q <= regWrData & wrMask;
            end
            // Only software ever loads the direction bits; overrides act downstream.
            if (isReg(regAddr, `PGPC_OFS_DIR)) begin
                dir_q <= regWrData | ~wrMask;
            end
            if (isReg(regAddr, `PGPC_OFS_ANSEL)) begin
                anaSel_q <= regWrData[`PGPC_ANA_PINS-1:0];
            end
            if (isReg(regAddr, `PGPC_OFS_ODSEL)) begin
                odSel_q <= regWrData[`PGPC_ANA_PINS-1:0];
            end
            if (isReg(regAddr, `PGPC_OFS_LCDSEG)) begin
                lcdSegEn_q <= regWrData[`PGPC_ANA_PINS-1:0];
            end
            if (isReg(regAddr, `PGPC_OFS_LCDCOM)) begin
                lcdComEn_q <= regWrData[`PGPC_COM_PINS-1:0];
            end
        end
    end

    // Pin levels are sampled once so every reader sees one consistent value.
    always @(posedge clk) begin
        if (rst) begin
            pinLevel_q <= 8'h00;
        end else begin
            pinLevel_q <= pinIn;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `PGPC_PINS; gi = gi + 1) begin : gPin
            wire lcdEn;
            wire lcdVal;
            wire perOutEn;
            wire perOut;
            wire perInForce;
            wire anaSel;
            wire odSel;
            if (gi < `PGPC_COM_PINS) begin : gCom
                // Common drive takes precedence over a segment on the same pin.
                assign lcdEn = lcdComEn_q[gi] | lcdSegEn_q[gi];
                assign lcdVal = lcdComEn_q[gi] ? lcdComLevel[gi] : lcdSegLevel[gi];
            end else if (gi < `PGPC_ANA_PINS) begin : gSeg
                assign lcdEn = lcdSegEn_q[gi];
                assign lcdVal = lcdSegLevel[gi];
            end else begin : gNoLcd
                assign lcdEn = 1'b0;
                assign lcdVal = 1'b0;
            end
            if (gi == `PGPC_ANA_PINS - 1) begin : gCal
                // The calendar output claims the pin ahead of a remapped output.
                assign perOutEn = clockCalendarOutEn | remapOutEn[gi];
                assign perOut = clockCalendarOutEn ? clockCalendarOut : remapOut[gi];
                assign perInForce = remapInForce[gi] & ~clockCalendarOutEn;
            end else if (gi < `PGPC_ANA_PINS) begin : gRemap
                assign perOutEn = remapOutEn[gi];
                assign perOut = remapOut[gi];
                assign perInForce = remapInForce[gi];
            end else begin : gPlain
                assign perOutEn = 1'b0;
                assign perOut = 1'b0;
                assign perInForce = 1'b0;
            end
            if (gi < `PGPC_ANA_PINS) begin : gAna
                assign anaSel = anaSel_q[gi];
                assign odSel = odSel_q[gi];
                assign routeHit[gi] = anaSel_q[gi] & ~lcdEn & (adcChannel == chanOfPin(gi));
            end else begin : gDig
                assign anaSel = 1'b0;
                assign odSel = 1'b0;
            end
            pgpc_pin_mux uMux (
                .dirIn(dir_q[gi]),
                .latchVal(latch_q[gi]),
                .analogSel(anaSel),
                .openDrain(odSel),
                .present(presentMask[gi]),
                .lcdEn(lcdEn),
                .lcdVal(lcdVal),
                .perOutEn(perOutEn),
                .perOut(perOut),
                .perInForce(perInForce),
                .pinLevel(pinLevel_q[gi]),
                .drvVal(muxVal[gi]),
                .drvEnN(muxEnN[gi]),
                .digIn(muxIn[gi])
            );
        end
    endgenerate

    // Pin drivers and peripheral inputs, all from flip-flops.
    always @(posedge clk) begin
        if (rst) begin
            pinOut_q <= 8'h00;
            pinOeN_q <= 8'hff;
            periphIn_q <= 8'h00;
            analogRoute_q <= 5'h00;
        end else begin
            pinOut_q <= muxVal;
            pinOeN_q <= muxEnN;
            periphIn_q <= muxIn;
            analogRoute_q <= routeHit;
        end
    end

    // Read mux; data stands in the cycle after the strobe and only there.
    always @* begin
        rdData_d = 8'h00;
        if (regRead) begin
            case (regAddr)
                `PGPC_OFS_PINS: rdData_d = muxIn & presentMask;
                `PGPC_OFS_LATCH: rdData_d = latch_q;
                `PGPC_OFS_DIR: rdData_d = dir_q;
                `PGPC_OFS_ANSEL: rdData_d = {3'h0, anaSel_q};
                `PGPC_OFS_ODSEL: rdData_d = {3'h0, odSel_q};
                `PGPC_OFS_LCDSEG: rdData_d = {3'h0, lcdSegEn_q};
                `PGPC_OFS_LCDCOM: rdData_d = {4'h0, lcdComEn_q};
                `PGPC_OFS_STATUS: rdData_d = {widePkg_q, 2'h0, analogRoute_q};
                default: rdData_d = 8'h00;
            endcase
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            regRdData_q <= 8'h00;
        end else begin
            regRdData_q <= rdData_d;
        end
    end

endmodule // pgpc_port

// ### pgpc_port_asserts.sv
// Checker of the seventh port's register and pin behaviour.
`timescale 1ns/1ps
module pgpc_port_asserts (
    // Clock, reset and strap.
    input wire logic clk,
    input wire logic rst,
    input wire logic widePackage,
    // Register port.
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdData_q,
    // Function inputs.
    input wire logic [3:0] lcdComLevel,
    input wire logic [4:0] remapOutEn,
    input wire logic [4:0] remapOut,
    input wire logic clockCalendarOutEn,
    input wire logic clockCalendarOut,
    input wire logic [4:0] adcChannel,
    // Pin side.
    input wire logic [7:0] pinOut_q,
    input wire logic [7:0] pinOeN_q,
    input wire logic [7:0] periphIn_q,
    input wire logic [4:0] analogRoute_q
);
    // Shadow copies only of the settings that the properties need.
    logic wide_q, dir5_q, lat5_q;
    logic [4:0] ana_q, seg_q;
    logic [3:0] com_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            wide_q <= widePackage;
            dir5_q <= 1'b1;
            lat5_q <= 1'b0;
            ana_q <= 5'h1f;
            seg_q <= 5'h00;
            com_q <= 4'h0;
        end else if (regWrite) begin
            if (regAddr < 4'h2) lat5_q <= regWrData[5];
            if (regAddr == 4'h2) dir5_q <= regWrData[5];
            if (regAddr == 4'h3) ana_q <= regWrData[4:0];
            if (regAddr == 4'h5) seg_q <= regWrData[4:0];
            if (regAddr == 4'h6) com_q <= regWrData[3:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence latchWr; regWrite && regAddr == 4'h1; endsequence
    sequence latchRd; regRead && regAddr == 4'h1; endsequence
    read_idle_a: assert property (!$past(regRead) |-> regRdData_q == 8'h00)
        else $error("read data not idle");
    latch_readback_a: assert property (latchWr ##2 latchRd |=>
        regRdData_q == ($past(regWrData, 3) & (wide_q ? 8'hff : 8'h3f))) else $error("latch read");
    unmapped_read_a: assert property (regRead && regAddr[3] |=> regRdData_q == 8'h00)
        else $error("unmapped read");
    reset_state_a: assert property ($fell(rst) |-> pinOeN_q == 8'hff)
        else $error("reset pin state");
    plain_dir_a: assert property (pinOeN_q[5] == $past(dir5_q)
        && (pinOeN_q[5] || pinOut_q[5] == $past(lat5_q))) else $error("plain pin");
    narrow_off_a: assert property (!wide_q |-> pinOeN_q[7:6] == 2'b11)
        else $error("absent pin driven");
    common_drive_a: assert property ($past(com_q[0]) |->
        !pinOeN_q[0] && pinOut_q[0] == $past(lcdComLevel[0])) else $error("common");
    seg_isolate_a: assert property ($past(seg_q[4]) && $past(seg_q[4], 2) |->
        !periphIn_q[4] && !pinOeN_q[4]) else $error("segment");
    analog_in_off_a: assert property ($past(ana_q[1]) && $past(ana_q[1], 2) |->
        !periphIn_q[1]) else $error("analog input");
    route_map_a: assert property ($past(!rst) |-> analogRoute_q[1] ==
        $past(ana_q[1] && !com_q[1] && !seg_q[1] && adcChannel == 5'h13)) else $error("route");
    forced_out_a: assert property ($past(remapOutEn[2] && !remapOut[2] && !com_q[2])
        |-> !pinOeN_q[2] && !pinOut_q[2]) else $error("forced output");
    calendar_out_a: assert property ($past(clockCalendarOutEn && !clockCalendarOut)
        && !$past(seg_q[4]) |-> !pinOeN_q[4] && !pinOut_q[4]) else $error("calendar");
endmodule // pgpc_port_asserts
bind pgpc_port pgpc_port_asserts pgpc_port_asserts_i (.clk, .rst, .widePackage, .regAddr,
    .regWrData, .regWrite, .regRead, .regRdData_q, .lcdComLevel, .remapOutEn, .remapOut,
    .clockCalendarOutEn, .clockCalendarOut, .adcChannel, .pinOut_q, .pinOeN_q, .periphIn_q,
    .analogRoute_q);

// ### pgpc_board.sv
// Board-side model of the seventh port's pins.
`timescale 1ns/1ps
module pgpc_board (
    // Device drive.
    input wire logic [7:0] drvVal,
    input wire logic [7:0] drvEnN,
    // Level the board puts on a released pin.
    input wire logic [7:0] boardLvl,
    // Pin levels seen by the device.
    output logic [7:0] pinLvl
);
    // A released pin must not echo the device's last value, so the board level wins there.
    assign pinLvl = (drvVal & ~drvEnN) | (boardLvl & drvEnN);
endmodule // pgpc_board

// ### test_pgpc_port.sv
// Self-checking bench of the seventh port.
`timescale 1ns/1ps
module test_pgpc_port;
    logic clk = 1'b0, rst = 1'b1, widePackage = 1'b1, regWrite = 1'b0, regRead = 1'b0;
    logic clockCalendarOutEn = 1'b0, clockCalendarOut = 1'b0;
    logic [3:0] regAddr = 4'h0, lcdComLevel = 4'h0;
    logic [7:0] regWrData = 8'h00, boardLvl = 8'h5a;
    logic [7:0] regRdData_q, pinIn, pinOut_q, pinOeN_q, periphIn_q;
    logic [4:0] lcdSegLevel = 5'h00, remapOutEn = 5'h00, remapOut = 5'h00;
    logic [4:0] remapInForce = 5'h00, adcChannel = 5'h00, analogRoute_q;
    int miscompares = 0, checks_done = 0;
    // Each row: write offset, write data, read offset, expected read data.
    logic [23:0] rows [8] = '{24'h1a51a5, 24'h03c13c, 24'h300300, 24'h200200,
        24'h196096, 24'h2ff05a, 24'h95a900, 24'h31f040};
    logic [4:0] chans [5] = '{5'h08, 5'h13, 5'h12, 5'h11, 5'h10};
    pgpc_port pgpc_port_i (.clk, .rst, .widePackage, .regAddr, .regWrData, .regWrite,
        .regRead, .regRdData_q, .lcdSegLevel, .lcdComLevel, .remapOutEn, .remapOut,
        .remapInForce, .clockCalendarOutEn, .clockCalendarOut, .adcChannel, .pinIn,
        .pinOut_q, .pinOeN_q, .periphIn_q, .analogRoute_q);
    pgpc_board pgpc_board_i (.drvVal(pinOut_q), .drvEnN(pinOeN_q), .boardLvl(boardLvl),
        .pinLvl(pinIn));
    always #5 clk = ~clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        // One idle cycle keeps back-to-back writes from lowering and raising the strobe at once.
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 chk(regRdData_q, exp);
        @(posedge clk);
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Nothing here waits on the design, so one overall limit is enough.
    initial begin
        #200000;
        miscompares++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(4'h2, 8'hff);
        rd(4'h3, 8'h1f);
        rd(4'h1, 8'h00);
        foreach (rows[i]) begin
            wr(rows[i][23:20], rows[i][19:12]);
            repeat (4) @(posedge clk);
            rd(rows[i][11:8], rows[i][7:0]);
        end
        wr(4'h1, 8'hc3);
        rd(4'h1, 8'hc3);
        for (int i = 0; i < 5; i++) begin
            adcChannel <= chans[i];
            settle();
            chk({3'h0, analogRoute_q}, 8'h01 << i);
        end
        remapOutEn <= 5'h04;
        settle();
        chk(pinOeN_q, 8'hfb);
        wr(4'h2, 8'hfb);
        rd(4'h2, 8'hfb);
        wr(4'h4, 8'h04);
        remapOut <= 5'h04;
        settle();
        chk(pinOeN_q, 8'hff);
        remapOutEn <= 5'h00;
        remapInForce <= 5'h04;
        settle();
        chk(pinOeN_q, 8'hff);
        remapInForce <= 5'h00;
        wr(4'h2, 8'hff);
        wr(4'h6, 8'h01);
        wr(4'h5, 8'h10);
        lcdComLevel <= 4'h1;
        lcdSegLevel <= 5'h10;
        clockCalendarOutEn <= 1'b1;
        settle();
        chk(pinOeN_q, 8'hee);
        chk(pinOut_q & 8'h11, 8'h11);
        wr(4'h6, 8'h00);
        wr(4'h5, 8'h00);
        settle();
        chk(pinOeN_q, 8'hef);
        clockCalendarOutEn <= 1'b0;
        adcChannel <= 5'h00;
        rst <= 1'b1;
        widePackage <= 1'b0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        wr(4'h1, 8'hff);
        rd(4'h1, 8'h3f);
        wr(4'h2, 8'h00);
        rd(4'h2, 8'hc0);
        print_verdict();
    end
endmodule // test_pgpc_port
